// *** rtp_port.sv ***
/*
 * Timed pattern output port: APB register slave, pattern buffer, output
 * latch loaded on the timer trigger, and registered pattern pins.
 * Assumes pclk at 100 MHz, inputs synchronous to pclk, and a one-cycle
 * trigger pulse from the timer.
 */
// Register access over APB is this design's own decision.
// Operation
// - Buffer is a four-bit low and two-bit high register
// - Four-bit mode uses low only, upper invalid
// - Six-bit write to either address sets both
// - Six-bit read of either returns combined pattern
// - High buffer holds only two bits
// - One enable bit per pin, one enables
// - Reset clears enable and modulation registers
// - Enables apply at trigger while output enabled
// - Select bit picks timer or pattern source
// - Bit 6 modulates even pattern outputs
// - Bit 5 modulates odd pattern outputs
// - Bit 4 inverts driven pattern
// - PWM signal comes from timer outputs
// - Modulation and inversion only when pattern selected
// - Trigger copies buffer to latch when enabled
// - Width select picks six or four bits
module rtp_port
  import rtp_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timer side
  input wire logic timer01_interrupt_event,
  input wire logic [5:0] inverter_timer_out,
  // Pattern pins
  output logic [5:0] pattern_pin
);

  // ***************************************************************
  // Declarations
  // ***************************************************************
  logic [7:0] mod_ctrl_reg;
  logic [7:0] pwm_sel_reg;
  logic [7:0] pin_en_reg;
  logic [5:0] pin_en_active_reg;
  logic [7:0] port_ctrl_reg;
  logic [3:0] buf_low_reg;
  logic [1:0] buf_high_reg;
  logic [5:0] latch_reg;
  logic [5:0] pin_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic access;
  logic wr_fire;
  logic addr_hit;
  logic six_bit;
  logic out_en;
  logic arm;
  logic [31:0] read_value;
  logic [5:0] pattern_next;

  mix_if mix ();

  // ***************************************************************
  // APB handshake: one wait state, write commits with pready high
  // ***************************************************************
  assign access = psel & penable;
  assign wr_fire = access & pwrite & pready_reg;
  assign six_bit = port_ctrl_reg[WIDTH_SEL_BIT];
  assign out_en = port_ctrl_reg[OUT_EN_BIT];
  assign arm = out_en & timer01_interrupt_event;

  always_comb begin
    addr_hit = 1'b1;
    read_value = 32'h0000_0000;
    unique case (paddr)
      MOD_CTRL_ADDR: read_value = {24'h00_0000, mod_ctrl_reg};
      PWM_SEL_ADDR: read_value = {24'h00_0000, pwm_sel_reg};
      PIN_EN_ADDR: read_value = {24'h00_0000, pin_en_reg};
      PORT_CTRL_ADDR: read_value = {24'h00_0000, port_ctrl_reg};
      LATCH_STAT_ADDR: read_value = {26'h000_0000, latch_reg};
      BUF_LOW_ADDR, BUF_HIGH_ADDR: begin
        if (six_bit) begin
          read_value = {26'h000_0000, buf_high_reg, buf_low_reg};
        end else if (paddr == BUF_LOW_ADDR) begin
          read_value = {28'h000_0000, buf_low_reg};
        end else begin
          read_value = {30'h0000_0000, buf_high_reg};
        end
      end
      default: addr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= access & ~pready_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (access & ~pready_reg & ~pwrite) begin
      prdata_reg <= read_value;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_reg <= 1'b0;
    end else begin
      pslverr_reg <= access & ~pready_reg & ~addr_hit;
    end
  end

  // ***************************************************************
  // Control registers
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mod_ctrl_reg <= MOD_CTRL_RST;
      pin_en_reg <= PIN_EN_RST;
      port_ctrl_reg <= PORT_CTRL_RST;
      pwm_sel_reg <= PWM_SEL_RST;
    end else if (wr_fire) begin
      if (paddr == MOD_CTRL_ADDR) begin
        mod_ctrl_reg <= pwdata[7:0] & MOD_CTRL_MASK;
      end
      if (paddr == PIN_EN_ADDR) begin
        pin_en_reg <= pwdata[7:0] & PIN_EN_MASK;
      end
      if (paddr == PORT_CTRL_ADDR) begin
        port_ctrl_reg <= pwdata[7:0] & PORT_CTRL_MASK;
      end
      if (paddr == PWM_SEL_ADDR) begin
        pwm_sel_reg <= pwdata[7:0] & PWM_SEL_MASK;
      end
    end
  end

  // Enables follow writes at once only while output is disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_en_active_reg <= PIN_EN_RST[5:0];
    end else if (!out_en || timer01_interrupt_event) begin
      pin_en_active_reg <= pin_en_reg[5:0];
    end
  end

  // ***************************************************************
  // Pattern buffer
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_low_reg <= BUF_LOW_RST;
      buf_high_reg <= BUF_HIGH_RST;
    end else if (wr_fire && (paddr == BUF_LOW_ADDR || paddr == BUF_HIGH_ADDR)) begin
      if (six_bit) begin
        buf_low_reg <= pwdata[3:0];
        buf_high_reg <= pwdata[5:4];
      end else if (paddr == BUF_LOW_ADDR) begin
        buf_low_reg <= pwdata[3:0];
      end
    end
  end

  // ***************************************************************
  // Output latch and pins
  // ***************************************************************
  assign pattern_next = six_bit ? {buf_high_reg, buf_low_reg} : {latch_reg[5:4], buf_low_reg};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_reg <= LATCH_RST;
    end else if (arm) begin
      latch_reg <= pattern_next;
    end
  end

  assign mix.latch = latch_reg;
  assign mix.pin_en = pin_en_active_reg;
  assign mix.timer_out = inverter_timer_out;
  assign mix.out_sel = mod_ctrl_reg[OUT_SEL_BIT];
  assign mix.even_pwm = mod_ctrl_reg[EVEN_PWM_BIT];
  assign mix.odd_pwm = mod_ctrl_reg[ODD_PWM_BIT];
  assign mix.invert = mod_ctrl_reg[INVERT_BIT];
  assign mix.pwm_src = pwm_sel_reg[PWM_SRC_BIT];

  pin_mixer u_mixer (
    .m(mix.mixer)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_reg <= LATCH_RST;
    end else begin
      pin_reg <= mix.pin_level;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign pattern_pin = pin_reg;

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence buf_write_s;
    wr_fire && (paddr == BUF_LOW_ADDR || paddr == BUF_HIGH_ADDR);
  endsequence

  sequence buf_read_s;
    access && !pready_reg && !pwrite && (paddr == BUF_LOW_ADDR || paddr == BUF_HIGH_ADDR);
  endsequence

  sequence pattern_only_s;
    mod_ctrl_reg[OUT_SEL_BIT] && !mod_ctrl_reg[EVEN_PWM_BIT] && !mod_ctrl_reg[ODD_PWM_BIT];
  endsequence

  buf_six_write_a: assert property (buf_write_s and six_bit |=>
    buf_low_reg == $past(pwdata[3:0]) && buf_high_reg == $past(pwdata[5:4]))
    else $error("six-bit buffer write did not set both halves");

  buf_four_write_a: assert property (wr_fire && !six_bit && paddr == BUF_HIGH_ADDR
    |=> $stable(buf_high_reg) && $stable(buf_low_reg))
    else $error("four-bit write to high buffer changed the buffer");

  buf_six_read_a: assert property (buf_read_s and six_bit |=> pready_reg &&
    prdata_reg == {26'h000_0000, $past(buf_high_reg), $past(buf_low_reg)})
    else $error("six-bit buffer read not combined");

  buf_high_bits_a: assert property (buf_read_s |=> prdata_reg[31:6] == 26'h000_0000)
    else $error("buffer read shows bits above the pattern");

  reset_clear_a: assert property ($rose(presetn) |->
    mod_ctrl_reg == 8'h00 && pin_en_reg == 8'h00)
    else $error("control registers not clear after reset");

  enable_sync_a: assert property (out_en && !timer01_interrupt_event
    |=> $stable(pin_en_active_reg))
    else $error("pin enables changed without a trigger");

  latch_load_a: assert property (arm && six_bit |=>
    latch_reg == {$past(buf_high_reg), $past(buf_low_reg)})
    else $error("trigger did not load the latch");

  latch_hold_a: assert property (!arm |=> $stable(latch_reg))
    else $error("latch changed between triggers");

  timer_route_a: assert property (!mod_ctrl_reg[OUT_SEL_BIT] && pwm_sel_reg[PWM_SRC_BIT]
    |=> pin_reg == $past(inverter_timer_out))
    else $error("timer outputs not routed to pins");

  invert_path_a: assert property (pattern_only_s |=> pin_reg ==
    ($past(pin_en_active_reg & latch_reg) ^ {6{$past(mod_ctrl_reg[INVERT_BIT])}}))
    else $error("pattern path wrong with modulation off");

  even_pwm_a: assert property (mod_ctrl_reg[OUT_SEL_BIT] && mod_ctrl_reg[EVEN_PWM_BIT] &&
    !mod_ctrl_reg[INVERT_BIT] && !pwm_sel_reg[PWM_SRC_BIT] |=> pin_reg[2] ==
    $past(pin_en_active_reg[2] & latch_reg[2] & inverter_timer_out[0]))
    else $error("even pin not modulated by timer output 0");

  odd_pwm_a: assert property (mod_ctrl_reg[OUT_SEL_BIT] && mod_ctrl_reg[ODD_PWM_BIT] &&
    !mod_ctrl_reg[INVERT_BIT] && pwm_sel_reg[PWM_SRC_BIT] |=> pin_reg[3] ==
    $past(pin_en_active_reg[3] & latch_reg[3] & inverter_timer_out[3]))
    else $error("odd pin not modulated by its own timer output");

  apb_answer_a: assert property (access && !pready_reg |=> pready_reg ##1 !pready_reg)
    else $error("slave answer not one cycle after access");

  // ***************************************************************
  // Register and pin checks
  // ***************************************************************
  sequence trigger_s;
    timer01_interrupt_event;
  endsequence

  sequence read_start_s;
    access && !pready_reg && !pwrite;
  endsequence

  four_latch_load_a: assert property (arm && !six_bit |=>
    latch_reg == {$past(latch_reg[5:4]), $past(buf_low_reg)})
    else $error("four-bit trigger did not load only the low bits");

  trigger_enable_a: assert property (trigger_s |=>
    pin_en_active_reg == $past(pin_en_reg[5:0]))
    else $error("pin enables not applied at the trigger");

  idle_enable_a: assert property (!out_en |=>
    pin_en_active_reg == $past(pin_en_reg[5:0]))
    else $error("pin enables not following the register while output is off");

  pattern_gate_a: assert property (mod_ctrl_reg[OUT_SEL_BIT] && !mod_ctrl_reg[INVERT_BIT] |=>
    (pin_reg & ~$past(pin_en_active_reg)) == 6'h00)
    else $error("disabled pin drives the pattern");

  timer_all_a: assert property (!mod_ctrl_reg[OUT_SEL_BIT] && !pwm_sel_reg[PWM_SRC_BIT] |=>
    pin_reg == {6{$past(inverter_timer_out[0])}})
    else $error("first timer output not routed to every pin");

  mod_write_a: assert property (wr_fire && paddr == MOD_CTRL_ADDR |=>
    mod_ctrl_reg == ($past(pwdata[7:0]) & MOD_CTRL_MASK))
    else $error("modulation control write not stored");

  enable_write_a: assert property (wr_fire && paddr == PIN_EN_ADDR |=>
    pin_en_reg == ($past(pwdata[7:0]) & PIN_EN_MASK))
    else $error("pin enable write not stored");

  four_low_write_a: assert property (wr_fire && !six_bit && paddr == BUF_LOW_ADDR |=>
    buf_low_reg == $past(pwdata[3:0]) && $stable(buf_high_reg))
    else $error("four-bit low buffer write wrong");

  four_read_a: assert property (read_start_s and !six_bit && paddr == BUF_LOW_ADDR |=>
    prdata_reg == {28'h000_0000, $past(buf_low_reg)})
    else $error("four-bit low buffer read shows high bits");

  read_hold_a: assert property (!(access && !pready_reg && !pwrite) |=>
    $stable(prdata_reg))
    else $error("read data changed without a read");

  unmapped_err_a: assert property (access && !pready_reg && !addr_hit |=>
    pslverr_reg && pready_reg)
    else $error("unmapped access not answered with an error");

endmodule

// *** rtp_pkg.sv ***
/*
 * Shared constants of the timed pattern output port: register byte
 * addresses, field positions, writable masks, reset values and widths.
 * Assumes a 16-bit APB byte address space with one 32-bit word per register.
 */
package rtp_pkg;

  // ***************************************************************
  // Register byte addresses
  // ***************************************************************
  localparam logic [15:0] MOD_CTRL_ADDR = 16'hff38;
  localparam logic [15:0] PWM_SEL_ADDR = 16'hff3c;
  localparam logic [15:0] BUF_LOW_ADDR = 16'hffb0;
  localparam logic [15:0] BUF_HIGH_ADDR = 16'hffb4;
  localparam logic [15:0] PIN_EN_ADDR = 16'hffbc;
  localparam logic [15:0] PORT_CTRL_ADDR = 16'hffc0;
  localparam logic [15:0] LATCH_STAT_ADDR = 16'hffc4;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int OUT_SEL_BIT = 7;
  localparam int EVEN_PWM_BIT = 6;
  localparam int ODD_PWM_BIT = 5;
  localparam int INVERT_BIT = 4;
  localparam int OUT_EN_BIT = 7;
  localparam int WIDTH_SEL_BIT = 5;
  localparam int PWM_SRC_BIT = 0;

  // ***************************************************************
  // Writable masks and reset values
  // ***************************************************************
  localparam logic [7:0] MOD_CTRL_MASK = 8'hf0;
  localparam logic [7:0] PIN_EN_MASK = 8'h3f;
  localparam logic [7:0] PORT_CTRL_MASK = 8'ha0;
  localparam logic [7:0] PWM_SEL_MASK = 8'h01;
  localparam logic [7:0] MOD_CTRL_RST = 8'h00;
  localparam logic [7:0] PIN_EN_RST = 8'h00;
  localparam logic [7:0] PORT_CTRL_RST = 8'h00;
  localparam logic [7:0] PWM_SEL_RST = 8'h00;
  localparam logic [3:0] BUF_LOW_RST = 4'h0;
  localparam logic [1:0] BUF_HIGH_RST = 2'h0;
  localparam logic [5:0] LATCH_RST = 6'h00;

  // ***************************************************************
  // Widths
  // ***************************************************************
  localparam int PIN_COUNT = 6;
  localparam int LOW_WIDTH = 4;
  localparam int HIGH_WIDTH = 2;

endpackage

// *** mix_if.sv ***
/*
 * Carrier between the port core and its per-pin output mixer.
 * Assumes both ends sit in the same clock domain.
 */
interface mix_if;
  logic [5:0] latch;
  logic [5:0] pin_en;
  logic [5:0] timer_out;
  logic out_sel;
  logic even_pwm;
  logic odd_pwm;
  logic invert;
  logic pwm_src;
  logic [5:0] pin_level;

  modport core (
    output latch, pin_en, timer_out, out_sel, even_pwm, odd_pwm, invert, pwm_src,
    input pin_level
  );
  modport mixer (
    input latch, pin_en, timer_out, out_sel, even_pwm, odd_pwm, invert, pwm_src,
    output pin_level
  );
endinterface

// *** pin_mixer.sv ***
/*
 * Per-pin combinational mixer: gates the latched pattern with the pin
 * enables, applies PWM modulation and inversion, and picks the pin source.
 * Assumes the core registers the result before it reaches a pin.
 */
module pin_mixer
  import rtp_pkg::*;
(
  mix_if.mixer m
);

  // ***************************************************************
  // Per-pin mixing
  // ***************************************************************
  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
    logic timer_sig;
    logic pwm_on;
    logic base;
    logic shaped;
    assign timer_sig = m.pwm_src ? m.timer_out[i] : m.timer_out[0];
    assign pwm_on = (i % 2 == 0) ? m.even_pwm : m.odd_pwm;
    assign base = m.pin_en[i] & m.latch[i];
    assign shaped = pwm_on ? (base & timer_sig) : base;
    // Modulation and inversion only matter on the pattern path
    assign m.pin_level[i] = m.out_sel ? (shaped ^ m.invert) : timer_sig;
  end

endmodule

// *** inverter_timer_model.sv ***
/*
 * Stand-in for the inverter timer that feeds the pattern port: a one-cycle
 * trigger pulse and six timer output levels.
 * Assumes the bench asks for each pulse and sets levels in step with pclk.
 */
module inverter_timer_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench requests
  input wire logic fire,
  input wire logic [5:0] level,
  // Timer outputs
  output logic timer01_interrupt_event,
  output logic [5:0] inverter_timer_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // ***************************************************************
  // Registered pulse and levels
  // ***************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer01_interrupt_event <= 1'b0;
      inverter_timer_out <= 6'h00;
    end else begin
      timer01_interrupt_event <= fire;
      inverter_timer_out <= level;
    end
  end
endmodule

// *** timed_pattern_output_port_test.sv ***
/*
 * Self-checking bench of the timed pattern output port: APB register
 * access, triggered latch loads, pin enables, modulation and inversion.
 * Assumes rtp_port and inverter_timer_model, pclk at 100 MHz.
 */
module timed_pattern_output_port_test
  import rtp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic trig;
  logic [5:0] tmr;
  logic [5:0] pins;
  logic [5:0] tmr_level = 6'h00;
  logic fire = 1'b0;
  logic [31:0] rd;
  logic err;
  int n_fail = 0;
  int n_tests = 0;

  always #5 pclk = ~pclk;

  rtp_port dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer01_interrupt_event(trig),
    .inverter_timer_out(tmr), .pattern_pin(pins)
  );

  inverter_timer_model timer (
    .pclk(pclk), .presetn(presetn), .fire(fire), .level(tmr_level),
    .timer01_interrupt_event(trig), .inverter_timer_out(tmr)
  );

  // ***************************************************************
  // Closing report
  // ***************************************************************
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ***************************************************************
  // Bus and trigger tasks
  // ***************************************************************
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      $display("[FAIL] %0t bus transfer timed out", $time);
      finish_test();
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  task automatic fire_trig();
    @(posedge pclk);
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
  endtask

  task automatic set_timer(input logic [5:0] v);
    @(posedge pclk);
    tmr_level <= v;
  endtask

  // ***************************************************************
  // Compare tasks
  // ***************************************************************
  task automatic chk_reg(input logic [15:0] a, input logic [31:0] exp, input logic exp_err);
    apb(1'b0, a, 32'h0);
    n_tests++;
    if ({err, rd} !== {exp_err, exp}) begin
      n_fail++;
      $display("[FAIL] %0t read %h gave %h/%b, expected %h/%b", $time, a, rd, err, exp,
               exp_err);
    end
  endtask

  task automatic chk_pins(input logic [5:0] exp);
    repeat (3) @(posedge pclk);
    n_tests++;
    if (pins !== exp) begin
      n_fail++;
      $display("[FAIL] %0t pins %h, expected %h", $time, pins, exp);
    end
  endtask

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    chk_reg(MOD_CTRL_ADDR, 32'h0, 1'b0);
    chk_reg(PIN_EN_ADDR, 32'h0, 1'b0);
    chk_reg(16'hff00, 32'h0, 1'b1);
    wr(MOD_CTRL_ADDR, 8'hff);
    chk_reg(MOD_CTRL_ADDR, 32'hf0, 1'b0);
    wr(PIN_EN_ADDR, 8'h3f);
    chk_reg(PIN_EN_ADDR, 32'h3f, 1'b0);
    wr(PORT_CTRL_ADDR, 8'h20);
    wr(BUF_HIGH_ADDR, 8'hed);
    chk_reg(BUF_LOW_ADDR, 32'h2d, 1'b0);
    chk_reg(BUF_HIGH_ADDR, 32'h2d, 1'b0);
    wr(MOD_CTRL_ADDR, 8'h80);
    chk_pins(6'h00);
    fire_trig();
    chk_pins(6'h00);
    wr(PORT_CTRL_ADDR, 8'ha0);
    chk_reg(PORT_CTRL_ADDR, 32'ha0, 1'b0);
    fire_trig();
    chk_pins(6'h2d);
    chk_reg(LATCH_STAT_ADDR, 32'h2d, 1'b0);
    wr(BUF_LOW_ADDR, 8'h12);
    chk_pins(6'h2d);
    fire_trig();
    chk_pins(6'h12);
    wr(BUF_LOW_ADDR, 8'h3f);
    wr(PIN_EN_ADDR, 8'h0f);
    chk_pins(6'h12);
    fire_trig();
    chk_pins(6'h0f);
    wr(MOD_CTRL_ADDR, 8'h90);
    chk_pins(6'h30);
    wr(MOD_CTRL_ADDR, 8'hc0);
    chk_pins(6'h0a);
    wr(MOD_CTRL_ADDR, 8'ha0);
    chk_pins(6'h05);
    set_timer(6'h15);
    wr(MOD_CTRL_ADDR, 8'he0);
    chk_pins(6'h0f);
    wr(PWM_SEL_ADDR, 8'hff);
    chk_reg(PWM_SEL_ADDR, 32'h01, 1'b0);
    chk_pins(6'h05);
    wr(MOD_CTRL_ADDR, 8'h70);
    chk_pins(6'h15);
    wr(PWM_SEL_ADDR, 8'h00);
    chk_pins(6'h3f);
    wr(MOD_CTRL_ADDR, 8'h80);
    wr(PIN_EN_ADDR, 8'h3f);
    wr(BUF_LOW_ADDR, 8'h0f);
    wr(PORT_CTRL_ADDR, 8'h80);
    wr(BUF_LOW_ADDR, 8'h0a);
    wr(BUF_HIGH_ADDR, 8'h33);
    chk_reg(BUF_HIGH_ADDR, 32'h0, 1'b0);
    chk_reg(BUF_LOW_ADDR, 32'ha, 1'b0);
    fire_trig();
    chk_pins(6'h3a);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    chk_reg(MOD_CTRL_ADDR, 32'h0, 1'b0);
    chk_reg(PIN_EN_ADDR, 32'h0, 1'b0);
    chk_reg(LATCH_STAT_ADDR, 32'h0, 1'b0);
    chk_pins(6'h3f);
    finish_test();
  end
endmodule
